// ===== core/usfc_baud_gen.sv
// Purpose: Baud prescaler giving one tick every divisor+1 clocks
// Assumes: load_i is a one-cycle pulse
// Notes:   Reload restarts the period at once
`include "usfc_map.svh"
`timescale 1ns/10ps
module usfc_baud_gen (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] div_i,
  input  wire logic        load_i,
  output logic             tick_o
);
  logic [11:0] cnt;
  logic [11:0] gap;
  logic [11:0] per;

  // divisor plus one
  // Down counter, reloaded on underflow or on load
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt    <= `USFC_DIV_RST;
      tick_o <= 1'b0;
    end
    else if (load_i)
    begin
      cnt    <= div_i;
      tick_o <= 1'b0;
    end
    else if (cnt == `USFC_DIV_RST)
    begin
      cnt    <= div_i;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt    <= cnt - 12'h001;
      tick_o <= 1'b0;
    end
  end

  // Helper: clocks since last tick, and the divisor that set this period
  // A load starts one below zero so the count lines up with an underflow
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gap <= ~`USFC_DIV_RST;
      per <= `USFC_DIV_RST;
    end
    else if (load_i)
    begin
      gap <= ~`USFC_DIV_RST;
      per <= div_i;
    end
    else
    begin
      gap <= tick_o ? `USFC_DIV_RST : gap + 12'h001;
      if (cnt == `USFC_DIV_RST)
        per <= div_i;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  baud_reload_a:
    assert property (load_i |=> cnt == $past(div_i))
    else $error("prescaler not reloaded by low divisor write");

  tick_period_a:
    assert property (tick_o |-> gap == $past(per))
    else $error("baud tick spacing differs from divisor plus one");
endmodule

// ===== core/usfc_map.svh
// Purpose: Register map, bit positions, reset values and counts
// Assumes: Word registers on a 32-bit bus, byte address = index * 4
// Notes:   Definitions only
`ifndef USFC_MAP_SVH
`define USFC_MAP_SVH
// Register word index
`define USFC_R_STAT  3'h0
`define USFC_R_CTRL  3'h1
`define USFC_R_FMT   3'h2
`define USFC_R_BDH   3'h3
`define USFC_R_BDL   3'h4
`define USFC_R_DATA  3'h5
`define USFC_R_IST   3'h6
`define USFC_R_IMSK  3'h7
`define USFC_ADR_OK  3'h0
`define USFC_LN_OK   2'h0
// Line status bits
`define USFC_SB_RXF  7
`define USFC_SB_TXI  5
`define USFC_SB_FE   4
`define USFC_SB_PE   2
`define USFC_SB_DBL  1
// Line control bits
`define USFC_CB_RXEN 4
`define USFC_CB_TXEN 3
`define USFC_CB_TOP  2
// Interrupt bits
`define USFC_IB_TX   0
`define USFC_IB_RX   1
`define USFC_IB_PE   2
// Reset values
`define USFC_FMT_RST 8'h06
`define USFC_DIV_RST 12'h000
`define USFC_IRQ_RST 3'h0
`define USFC_W9_RST  9'h000
`define USFC_CNT_RST 4'h0
// Oversample ticks per bit, minus one
`define USFC_OS_NRM  4'hF
`define USFC_OS_DBL  4'h7
// Data bits per character
`define USFC_NB_5    4'h5
`define USFC_NB_6    4'h6
`define USFC_NB_7    4'h7
`define USFC_NB_8    4'h8
`define USFC_NB_9    4'h9
`endif

// ===== core/usfc_pkg.sv
// Purpose: Shared types of the frame and baud block
// Assumes: Constants live in usfc_map.svh
// Notes:   Nothing here is imported; use usfc_pkg::name
package usfc_pkg;
  typedef enum logic [1:0] {
    MODE_ASYNC = 2'h0,
    MODE_SYNC  = 2'h1,
    MODE_RSV   = 2'h2,
    MODE_SPI   = 2'h3
  } usfc_mode_e;
  // Gray codes along idle-start-data-parity-stop
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h3,
    ST_PAR   = 3'h2,
    ST_STOP  = 3'h6,
    ST_STOP2 = 3'h7
  } usfc_state_e;
  typedef struct packed {
    usfc_mode_e mode;
    logic [1:0] parity;
    logic       stop;
    logic [1:0] size;
    logic       pol;
  } usfc_fmt_s;
  typedef struct packed {
    logic pe;
    logic rx;
    logic tx;
  } usfc_evt_s;
endpackage

// ===== core/usfc_sync2.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Pins idle high
// Notes:   First stage is read by the second stage only
`timescale 1ns/10ps
module usfc_sync2 #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // Two stages against metastability
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '1;
      q_o  <= '1;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// ===== core/usfc_top.sv
// Purpose: Frame format and baud configuration with serial engine
// Assumes: Classic Wishbone slave, 25 MHz clk_i, synchronous reset
// Notes:   One ack cycle per request; writes land at the ack edge
`include "usfc_map.svh"
`timescale 1ns/10ps
module usfc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  output logic             transmit_pin_o,
  input  wire logic        receive_pin_i,
  input  wire logic        serial_clock_i,
  output logic             serial_clock_o,
  output logic             serial_clock_oe_o
);
  usfc_pkg::usfc_fmt_s   fmt;
  usfc_pkg::usfc_state_e tx_st;
  usfc_pkg::usfc_state_e rx_st;
  usfc_pkg::usfc_evt_s   evt;
  logic [2:0]  irq_st;
  logic [2:0]  irq_msk;
  logic [11:0] div;
  logic [8:0]  tx_word;
  logic [8:0]  rx_sh;
  logic [8:0]  rx_data;
  logic [3:0]  tx_idx;
  logic [3:0]  rx_idx;
  logic [3:0]  tx_os;
  logic [3:0]  rx_os;
  logic [3:0]  nbits;
  logic [3:0]  os_max;
  logic [3:0]  rx_tgt;
  logic [1:0]  pin_q;
  logic [31:0] next_rdata;
  logic        rx_en;
  logic        tx_en;
  logic        size_top;
  logic        dbl;
  logic        tx_pend;
  logic        rx_full;
  logic        pe_flag;
  logic        fe_flag;
  logic        rx_par;
  logic        sclk_d;
  logic        bg_tick;
  logic        rxd;
  logic        sclk_src;
  logic        launch;
  logic        capture;
  logic        is_async;
  logic        rsv;
  logic        par_en;
  logic        tx_step;
  logic        rx_step;
  logic        wr;
  logic        rd;
  logic        hit;
  logic        div_load;
  logic [2:0]  idx;

  // ************************************************************
  // Helpers
  // ************************************************************

  // Data bits per character; reserved codes fall back to eight
  function automatic logic [3:0] char_bits(input logic top, input logic [1:0] code);
    case ({top, code})
      3'h0:    char_bits = `USFC_NB_5;
      3'h1:    char_bits = `USFC_NB_6;
      3'h2:    char_bits = `USFC_NB_7;
      3'h7:    char_bits = `USFC_NB_9;
      default: char_bits = `USFC_NB_8;
    endcase
  endfunction

  // Parity over the active data bits, odd when odd_i is set
  function automatic logic calc_par(input logic [8:0] w, input logic [3:0] n,
                                    input logic odd_i);
    logic p;
    p = odd_i;
    for (int i = 0; i < 9; i++)
      if (4'(i) < n)
        p = p ^ w[i];
    calc_par = p;
  endfunction

  // ************************************************************
  // Pins and clocking
  // ************************************************************

  usfc_sync2 #(.W(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({serial_clock_i, receive_pin_i}),
    .q_o   (pin_q)
  );

  usfc_baud_gen u_baud (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .div_i  (div),
    .load_i (div_load),
    .tick_o (bg_tick)
  );

  // Shared decode of mode, parity and edges
  always_comb
  begin
    rxd      = pin_q[0];
    is_async = fmt.mode == usfc_pkg::MODE_ASYNC;
    rsv      = fmt.mode == usfc_pkg::MODE_RSV;
    par_en   = fmt.parity[1];
    nbits    = char_bits(size_top, fmt.size);
    os_max   = dbl ? `USFC_OS_DBL : `USFC_OS_NRM;
    rx_tgt   = (rx_st == usfc_pkg::ST_START) ? {1'b0, os_max[3:1]} : os_max;
    sclk_src = (fmt.mode == usfc_pkg::MODE_SPI) ? serial_clock_o : pin_q[1];
    launch   = fmt.pol ? (sclk_d && !sclk_src) : (!sclk_d && sclk_src);
    capture  = fmt.pol ? (!sclk_d && sclk_src) : (sclk_d && !sclk_src);
    tx_step  = is_async ? (bg_tick && tx_os == os_max) : launch;
    rx_step  = is_async ? (bg_tick && rx_os == rx_tgt) : capture;
  end

  // reload after write
  // The load waits one cycle so the prescaler sees the new low byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_load <= 1'b0;
    else
      div_load <= wr && idx == `USFC_R_BDL;
  end

  // mode decode
  // Master clock on the pin in mode 11; input otherwise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      serial_clock_o    <= 1'b0;
      serial_clock_oe_o <= 1'b0;
      sclk_d            <= 1'b0;
    end
    else
    begin
      serial_clock_oe_o <= fmt.mode == usfc_pkg::MODE_SPI;
      if (fmt.mode == usfc_pkg::MODE_SPI && bg_tick)
        serial_clock_o <= !serial_clock_o;
      sclk_d <= sclk_src;
    end
  end

  // ************************************************************
  // Wishbone slave
  // ************************************************************

  // Request is taken at the edge where ack is seen high
  always_comb
  begin
    idx = wb_adr_i[4:2];
    hit = wb_adr_i[7:5] == `USFC_ADR_OK && wb_adr_i[1:0] == `USFC_LN_OK;
    wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && hit && wb_sel_i[0];
    rd  = wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i && hit;
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = '0;
    if (hit)
      case (idx)
        `USFC_R_STAT:
        begin
          next_rdata[`USFC_SB_RXF] = rx_full;
          next_rdata[`USFC_SB_TXI] = !tx_pend && tx_st == usfc_pkg::ST_IDLE;
          next_rdata[`USFC_SB_FE]  = fe_flag;
          next_rdata[`USFC_SB_PE]  = pe_flag;
          next_rdata[`USFC_SB_DBL] = dbl;
        end
        `USFC_R_CTRL:
        begin
          next_rdata[`USFC_CB_RXEN] = rx_en;
          next_rdata[`USFC_CB_TXEN] = tx_en;
          next_rdata[`USFC_CB_TOP]  = size_top;
        end
        `USFC_R_FMT:  next_rdata[7:0] = fmt;
        `USFC_R_BDH:  next_rdata[3:0] = div[11:8];
        `USFC_R_BDL:  next_rdata[7:0] = div[7:0];
        `USFC_R_DATA: next_rdata[8:0] = rx_data;
        `USFC_R_IST:  next_rdata[2:0] = irq_st;
        `USFC_R_IMSK: next_rdata[2:0] = irq_msk;
        default:      next_rdata = '0;
      endcase
  end

  // One-cycle ack with registered read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= next_rdata;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fmt      <= `USFC_FMT_RST;
      div      <= `USFC_DIV_RST;
      rx_en    <= 1'b0;
      tx_en    <= 1'b0;
      size_top <= 1'b0;
      dbl      <= 1'b0;
      irq_msk  <= `USFC_IRQ_RST;
    end
    else if (wr)
      case (idx)
        `USFC_R_STAT: dbl <= wb_dat_i[`USFC_SB_DBL];
        `USFC_R_CTRL:
        begin
          rx_en    <= wb_dat_i[`USFC_CB_RXEN];
          tx_en    <= wb_dat_i[`USFC_CB_TXEN];
          size_top <= wb_dat_i[`USFC_CB_TOP];
        end
        `USFC_R_FMT:  fmt <= wb_dat_i[7:0];
        `USFC_R_BDH:  div[11:8] <= wb_dat_i[3:0];
        `USFC_R_BDL:  div[7:0] <= wb_dat_i[7:0];
        `USFC_R_IMSK: irq_msk <= wb_dat_i[2:0];
        default:      irq_msk <= irq_msk;
      endcase
  end

  // ************************************************************
  // Interrupts
  // ************************************************************

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_st <= `USFC_IRQ_RST;
      irq_o  <= 1'b0;
    end
    else
    begin
      irq_st <= (irq_st & ~((wr && idx == `USFC_R_IST) ? wb_dat_i[2:0] : 3'h0)) | evt;
      irq_o  <= |(irq_st & irq_msk);
    end
  end

  // ************************************************************
  // Transmitter
  // ************************************************************

  // Data write queues a character only while enabled, idle and with none already waiting
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_pend <= 1'b0;
      tx_word <= `USFC_W9_RST;
    end
    else if (wr && idx == `USFC_R_DATA && tx_en && !tx_pend &&
             tx_st == usfc_pkg::ST_IDLE)
    begin
      tx_pend <= 1'b1;
      tx_word <= wb_dat_i[8:0];
    end
    else if (tx_st == usfc_pkg::ST_START)
      tx_pend <= 1'b0;
  end

  // Frame sequencer; reserved mode holds the line idle
  always_ff @(posedge clk_i)
  begin
    if (rst_i || rsv)
    begin
      tx_st          <= usfc_pkg::ST_IDLE;
      tx_idx         <= `USFC_CNT_RST;
      tx_os          <= `USFC_CNT_RST;
      transmit_pin_o <= 1'b1;
      evt.tx         <= 1'b0;
    end
    else
    begin
      evt.tx <= 1'b0;
      if (tx_st == usfc_pkg::ST_IDLE)
        tx_os <= `USFC_CNT_RST;
      else if (bg_tick)
        tx_os <= (tx_os == os_max) ? `USFC_CNT_RST : tx_os + 4'h1;
      case (tx_st)
        usfc_pkg::ST_IDLE:
          if (tx_pend && (is_async || launch))
          begin
            tx_st          <= usfc_pkg::ST_START;
            transmit_pin_o <= 1'b0;
          end
        usfc_pkg::ST_START:
          if (tx_step)
          begin
            tx_st          <= usfc_pkg::ST_DATA;
            tx_idx         <= `USFC_CNT_RST;
            transmit_pin_o <= tx_word[0];
          end
        usfc_pkg::ST_DATA:
          if (tx_step && tx_idx == nbits - 4'h1)
          begin
            tx_st          <= par_en ? usfc_pkg::ST_PAR : usfc_pkg::ST_STOP;
            transmit_pin_o <= par_en ? calc_par(tx_word, nbits, fmt.parity[0]) : 1'b1;
          end
          else if (tx_step)
          begin
            tx_idx         <= tx_idx + 4'h1;
            transmit_pin_o <= tx_word[tx_idx + 4'h1];
          end
        usfc_pkg::ST_PAR:
          if (tx_step)
          begin
            tx_st          <= usfc_pkg::ST_STOP;
            transmit_pin_o <= 1'b1;
          end
        usfc_pkg::ST_STOP:
          if (tx_step)
          begin
            tx_st  <= fmt.stop ? usfc_pkg::ST_STOP2 : usfc_pkg::ST_IDLE;
            evt.tx <= !fmt.stop;
          end
        usfc_pkg::ST_STOP2:
          if (tx_step)
          begin
            tx_st  <= usfc_pkg::ST_IDLE;
            evt.tx <= 1'b1;
          end
        default: tx_st <= usfc_pkg::ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Receiver
  // ************************************************************

  // One stop bit is checked whatever the stop select says
  always_ff @(posedge clk_i)
  begin
    if (rst_i || rsv || !rx_en)
    begin
      rx_st  <= usfc_pkg::ST_IDLE;
      rx_idx <= `USFC_CNT_RST;
      rx_os  <= `USFC_CNT_RST;
      rx_sh  <= `USFC_W9_RST;
      rx_par <= 1'b0;
    end
    else
    begin
      if (rx_st == usfc_pkg::ST_IDLE || rx_step)
        rx_os <= `USFC_CNT_RST;
      else if (bg_tick)
        rx_os <= rx_os + 4'h1;
      case (rx_st)
        usfc_pkg::ST_IDLE:
          if (!rxd && (is_async || capture))
            rx_st <= is_async ? usfc_pkg::ST_START : usfc_pkg::ST_DATA;
        usfc_pkg::ST_START:
          // Mid-bit recheck rejects glitches
          if (rx_step)
            rx_st <= rxd ? usfc_pkg::ST_IDLE : usfc_pkg::ST_DATA;
        usfc_pkg::ST_DATA:
          if (rx_step)
          begin
            rx_sh[rx_idx] <= rxd;
            rx_idx        <= (rx_idx == nbits - 4'h1) ? `USFC_CNT_RST : rx_idx + 4'h1;
            if (rx_idx == nbits - 4'h1)
              rx_st <= par_en ? usfc_pkg::ST_PAR : usfc_pkg::ST_STOP;
          end
        usfc_pkg::ST_PAR:
          if (rx_step)
          begin
            rx_par <= rxd;
            rx_st  <= usfc_pkg::ST_STOP;
          end
        usfc_pkg::ST_STOP:
          if (rx_step)
            rx_st <= usfc_pkg::ST_IDLE;
        default: rx_st <= usfc_pkg::ST_IDLE;
      endcase
    end
  end

  // Received character, flags and events
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !rx_en)
    begin
      rx_data <= `USFC_W9_RST;
      rx_full <= 1'b0;
      pe_flag <= 1'b0;
      fe_flag <= 1'b0;
      evt.rx  <= 1'b0;
      evt.pe  <= 1'b0;
    end
    else
    begin
      evt.rx <= 1'b0;
      evt.pe <= 1'b0;
      if (rx_st == usfc_pkg::ST_STOP && rx_step)
      begin
        rx_data <= rx_sh & ~(9'h1FF << nbits);
        rx_full <= 1'b1;
        fe_flag <= !rxd;
        pe_flag <= par_en && rx_par != calc_par(rx_sh, nbits, fmt.parity[0]);
        evt.pe  <= par_en && rx_par != calc_par(rx_sh, nbits, fmt.parity[0]);
        evt.rx  <= 1'b1;
      end
      else if (rd && idx == `USFC_R_DATA)
        rx_full <= 1'b0;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence hi_write;
    wr && idx == `USFC_R_BDH;
  endsequence

  sequence rx_last;
    rx_st == usfc_pkg::ST_STOP && rx_step;
  endsequence

  mode_rsv_a:
    assert property (rsv |=> tx_st == usfc_pkg::ST_IDLE && transmit_pin_o)
    else $error("reserved mode did not idle the transmitter");

  tx_parity_a:
    assert property (tx_st == usfc_pkg::ST_PAR |->
                     transmit_pin_o == calc_par(tx_word, nbits, fmt.parity[0]))
    else $error("parity bit on line is wrong");

  rx_perr_a:
    assert property (rx_last ##1 (rx_en && !rsv) |->
                     pe_flag == (par_en && $past(rx_par) !=
                                 calc_par($past(rx_sh), nbits, fmt.parity[0])))
    else $error("parity error flag disagrees with received parity");

  tx_stops_a:
    assert property ((tx_st == usfc_pkg::ST_STOP && tx_step && !rsv) |=>
                     tx_st == ($past(fmt.stop) ? usfc_pkg::ST_STOP2 : usfc_pkg::ST_IDLE))
    else $error("stop bit count wrong");

  tx_bits_a:
    assert property ((tx_st == usfc_pkg::ST_DATA && tx_step && !rsv &&
                      tx_idx != nbits - 4'h1) |=> tx_st == usfc_pkg::ST_DATA)
    else $error("data phase ended early");

  sync_edge_a:
    assert property ((!is_async && !rsv && tx_st != usfc_pkg::ST_IDLE && !tx_step) |=>
                     $stable(transmit_pin_o))
    else $error("sync transmit data moved off the launch edge");

  div_high_a:
    assert property (hi_write |=> div[11:8] == $past(wb_dat_i[3:0]))
    else $error("high divisor bits not stored");

  dbl_ticks_a:
    assert property ((is_async && tx_step) |-> tx_os == (dbl ? 4'h7 : 4'hF))
    else $error("ticks per bit wrong for speed setting");

  // Bus ack is one cycle
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule

// ===== dv/testbench.sv
// Purpose: Self-checking bench for the frame and baud block
// Assumes: Divisor 1, so a bit is 32 clocks, 16 at double speed
// Notes:   Random data from a fixed seed
`timescale 1ns/10ps
module testbench;
  // ****************
  // Signals
  // ****************
  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq_o;
  logic        tx_o, rx_i;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic [3:0]  wb_sel_i;
  logic [11:0] f;
  logic [8:0]  d, m;
  logic [1:0]  par;
  int          miscompares, checks_done, k, n, pe, bt;
  usfc_top i_dut (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .wb_adr_i          (wb_adr_i),
    .wb_dat_i          (wb_dat_i),
    .wb_sel_i          (wb_sel_i),
    .wb_we_i           (wb_we_i),
    .wb_cyc_i          (wb_cyc_i),
    .wb_stb_i          (wb_stb_i),
    .wb_dat_o          (wb_dat_o),
    .wb_ack_o          (wb_ack_o),
    .irq_o             (irq_o),
    .transmit_pin_o    (tx_o),
    .receive_pin_i     (rx_i),
    .serial_clock_i    (1'b1),
    .serial_clock_o    (),
    .serial_clock_oe_o ()
  );
  usfc_remote i_rem (
    .clk_i (clk_i),
    .tx_i  (tx_o),
    .rx_o  (rx_i)
  );
  // ****************
  // Tasks
  // ****************
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Classic cycle held until the ack edge; a lost ack ends the run
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= v;
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (wb_ack_o !== 1'b1 && i < 50);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i >= 50)
    begin
      miscompares++;
      final_report();
    end
  endtask
  // ****************
  // Sequence
  // ****************
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    rst_i    = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    void'($urandom(32'h98A5));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h08, 32'h0);
    chk("format reset", 32'h06, r);
    wb(1'b0, 8'h0C, 32'h0);
    chk("divisor reset", 32'h0, r);
    wb_sel_i <= 4'h0;
    wb(1'b1, 8'h08, 32'hFF);
    wb_sel_i <= 4'hF;
    wb(1'b1, 8'h20, 32'hFF);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, r);
    wb(1'b0, 8'h08, 32'h0);
    chk("format no lane", 32'h06, r);
    // Upper four bits written as zero by software
    // high then low
    wb(1'b1, 8'h0C, 32'h0A);
    wb(1'b0, 8'h0C, 32'h0);
    chk("divisor high", 32'h0A, r);
    wb(1'b1, 8'h0C, 32'h00);
    wb(1'b1, 8'h10, 32'h01);
    wb(1'b0, 8'h10, 32'h0);
    chk("divisor low", 32'h01, r);
    // Sizes 5 to 9, every parity code, both stop counts, double speed
    for (k = 0; k < 5; k++)
    begin
      n   = (k == 4) ? 9 : k + 5;
      par = (k == 1 || k == 4) ? 2'h2 : (k == 3) ? 2'h3 : (k == 2) ? 2'h1 : 2'h0;
      pe  = par[1];
      bt  = (k == 2) ? 16 : 32;
      d   = 9'($urandom);
      m   = 9'((1 << n) - 1);
      wb(1'b1, 8'h04, {27'h0, 2'h3, (k == 4), 2'h0});
      wb(1'b1, 8'h00, {30'h0, (k == 2), 1'b0});
      wb(1'b1, 8'h08, {26'h0, par, k[0] == 1'b1, (k == 4) ? 2'h3 : 2'(k), 1'b0});
      wb(1'b1, 8'h14, {23'h0, d});
      i_rem.take(bt, n, pe, f);
      chk("tx data", 32'(d & m), 32'(f[8:0] & m));
      if (pe == 1)
        chk("tx parity", 32'(par[0] ^ (^(d & m))), 32'(f[n]));
      chk("tx stop", 32'h1, 32'(f[n + pe]));
      repeat (2 * bt) @(posedge clk_i);
    end
    // Reserved mode must keep the line idle; size top back to zero
    wb(1'b1, 8'h04, 32'h18);
    wb(1'b1, 8'h08, 32'h86);
    repeat (8) @(posedge clk_i);
    chk("reserved idle", 32'h1, 32'(tx_o));
    // Own clock mode: data moves on launch edges, four clocks a bit
    d = 9'($urandom);
    wb(1'b1, 8'h08, 32'hC6);
    wb(1'b1, 8'h14, {23'h0, d});
    i_rem.take(4, 8, 0, f);
    chk("clocked data", 32'(d[7:0]), 32'(f[7:0]));
    chk("clocked stop", 32'h1, 32'(f[8]));
    repeat (16) @(posedge clk_i);
    wb(1'b1, 8'h08, 32'h26);
    wb(1'b1, 8'h1C, 32'h4);
    wb(1'b1, 8'h18, 32'h7);
    // Good parity first, then a broken one
    for (k = 0; k < 2; k++)
    begin
      d = 9'($urandom);
      i_rem.send(32, d[7:0], (^d[7:0]) ^ k[0]);
      repeat (64) @(posedge clk_i);
      wb(1'b0, 8'h00, 32'h0);
      chk("rx parity flag", 32'(k[0]), 32'(r[2]));
      wb(1'b0, 8'h14, 32'h0);
      chk("rx data", 32'(d[7:0]), r & 32'hFF);
      chk("irq line", 32'(k[0]), 32'(irq_o));
    end
    wb(1'b1, 8'h1C, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 32'h0, 32'(irq_o));
    wb(1'b1, 8'h1C, 32'h4);
    wb(1'b1, 8'h18, 32'h4);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0, 32'(irq_o));
    final_report();
  end
endmodule

// ===== dv/usfc_remote.sv
// Purpose: Remote serial transceiver model on the line side
// Assumes: Async framing, bit time given in clocks by the caller
// Notes:   Receive line idles high like a pulled-up pin
`timescale 1ns/10ps
module usfc_remote (
  input  wire logic clk_i,
  input  wire logic tx_i,
  output logic      rx_o
);
  // ****************
  // Line model
  // ****************
  initial rx_o = 1'b1;
  // Samples mid-bit; with no start bit in 20000 clocks it samples the idle line
  // frame decode
  task automatic take(input int bt, input int n, input int p, output logic [11:0] f);
    int i;
    f = '0;
    i = 0;
    while (tx_i === 1'b1 && i < 20000)
    begin
      @(posedge clk_i);
      i++;
    end
    repeat (bt / 2) @(posedge clk_i);
    for (i = 0; i < n + p + 1; i++)
    begin
      repeat (bt) @(posedge clk_i);
      f[i] = tx_i;
    end
  endtask
  task automatic send(input int bt, input logic [7:0] d, input logic pb);
    logic [10:0] w;
    int          i;
    w = {1'b1, pb, d, 1'b0};
    for (i = 0; i < 11; i++)
    begin
      @(posedge clk_i);
      rx_o <= w[i];
      repeat (bt - 1) @(posedge clk_i);
    end
  endtask
endmodule
